// ==== rtl/ssfd_pkg.sv ====
package ssfd_pkg;
    // word layout on the serial link
    localparam int WORD_W = 24;
    localparam int SEL_W = 2;
    localparam logic [1:0] SEL_CTL = 2'h0;
    localparam logic [1:0] SEL_REF = 2'h1;
    localparam logic [1:0] SEL_FB = 2'h2;
    localparam logic [1:0] SEL_TEST = 2'h3;
    // control latch fields
    localparam int CTL_PRE_LSB = 22;
    localparam int CTL_PD1 = 20;
    localparam int CTL_CP3S = 9;
    localparam int CTL_MUX_LSB = 5;
    localparam int CTL_CR = 4;
    // feedback latch fields
    localparam int FB_B_LSB = 8;
    localparam int FB_B_W = 13;
    localparam int FB_A_LSB = 2;
    localparam int FB_A_W = 5;
    localparam logic [12:0] B_MIN = 13'h0003;
    // prescaler modulus codes and 4/5 core counts
    localparam logic [1:0] PRE_8 = 2'h0;
    localparam logic [1:0] PRE_16 = 2'h1;
    localparam logic [2:0] GRP_LAST_8 = 3'h1;
    localparam logic [2:0] GRP_LAST_16 = 3'h3;
    localparam logic [2:0] GRP_LAST_32 = 3'h7;
    localparam logic [2:0] CORE_LO_LAST = 3'h3;
    localparam logic [2:0] CORE_HI_LAST = 3'h4;
    localparam logic [18:0] PRE_BASE = 19'h00008;
    // observation select codes
    localparam logic [2:0] MUX_LOCK = 3'h1;
    localparam logic [2:0] MUX_FB = 3'h2;
    localparam logic [2:0] MUX_REF = 3'h4;
    // controller register map (apb byte offsets)
    localparam logic [11:0] REG_WORD = 12'h000;
    localparam logic [11:0] REG_CTRL = 12'h004;
    localparam logic [11:0] REG_STAT = 12'h008;
    localparam logic [11:0] REG_MASK = 12'h00c;
    localparam int ST_DONE = 0;
    localparam int ST_DROP = 1;
    localparam int ST_BUSY = 2;
    localparam int ST_OBS = 3;
    // serial clock half period
    localparam int CLK_NS = 50;
    localparam int SCLK_HALF_NS = 25;
    localparam int SCLK_HALF_CYC_R = (SCLK_HALF_NS + CLK_NS - 1) / CLK_NS;
    localparam int SCLK_HALF_CYC = (SCLK_HALF_CYC_R < 1) ? 1 : SCLK_HALF_CYC_R;
    // controller sequencer
    typedef enum logic [2:0] {
        HS_IDLE = 3'b001,
        HS_SHIFT = 3'b010,
        HS_LOAD = 3'b100
    } ssfd_hstate_t;
endpackage : ssfd_pkg

// ==== rtl/ssfd_link_if.sv ====
`timescale 1ns/1ps
interface ssfd_link_if;
    logic sclk;
    logic sdata;
    logic load_strobe;
    logic chip_enable;
    logic observation_output_pin;
    modport host (
        output sclk,
        output sdata,
        output load_strobe,
        output chip_enable,
        input observation_output_pin
    );
    modport dev (
        input sclk,
        input sdata,
        input load_strobe,
        input chip_enable,
        output observation_output_pin
    );
endinterface : ssfd_link_if

// ==== rtl/ssfd_prescaler.sv ====
`timescale 1ns/1ps
module ssfd_prescaler (
    // system
    input wire logic pclk,
    input wire logic presetn,
    // rf cycle enable and modulus control
    input wire logic tick,
    input wire logic run,
    input wire logic [1:0] mode,
    input wire logic hi_mod,
    // one pulse per prescaler output cycle
    output logic out_pulse
);
    import ssfd_pkg::*;

    logic [2:0] core_ff;
    logic [2:0] grp_ff;
    logic out_ff;

    // one 4/5 core serves all pairs; only the group count differs
    wire [2:0] grp_last = (mode == PRE_8) ? GRP_LAST_8 :
                          (mode == PRE_16) ? GRP_LAST_16 : GRP_LAST_32;
    wire core_five = hi_mod & (grp_ff == 3'h0);
    wire [2:0] core_last = core_five ? CORE_HI_LAST : CORE_LO_LAST;
    wire core_end = tick & (core_ff == core_last);
    wire grp_end = core_end & (grp_ff == grp_last);

    // core and group counters, held cleared while stopped
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            core_ff <= 3'h0;
            grp_ff <= 3'h0;
            out_ff <= 1'b0;
        end else if (!run) begin
            core_ff <= 3'h0;
            grp_ff <= 3'h0;
            out_ff <= 1'b0;
        end else begin
            if (tick) begin
                core_ff <= core_end ? 3'h0 : core_ff + 3'h1;
            end
            if (core_end) begin
                grp_ff <= grp_end ? 3'h0 : grp_ff + 3'h1;
            end
            out_ff <= grp_end;
        end
    end

    assign out_pulse = out_ff;
endmodule : ssfd_prescaler

// ==== rtl/ssfd_device.sv ====
// The register addresses and register access over APB were chosen for this implementation.
`timescale 1ns/1ps
module ssfd_device (
    // system
    input wire logic pclk,
    input wire logic presetn,
    // serial programming link
    ssfd_link_if.dev link,
    // rf and reference cycle enables, lock indication
    input wire logic rf_tick,
    input wire logic ref_tick,
    input wire logic lock_detect,
    // feedback divider output
    output logic feedback_pulse,
    // power and pump state
    output logic powered_up,
    output logic charge_pump_output_en,
    output logic ref_series_switch_one_closed,
    output logic ref_series_switch_two_closed,
    output logic ref_shunt_switch_closed,
    // latch contents for the neighbouring sections
    output logic [ssfd_pkg::WORD_W-1:0] control_latch,
    output logic [ssfd_pkg::WORD_W-1:0] reference_latch,
    output logic [ssfd_pkg::WORD_W-1:0] feedback_latch,
    output logic [ssfd_pkg::WORD_W-1:0] test_latch
);
    import ssfd_pkg::*;

    logic [3:0] sync1_ff;
    logic [3:0] sync2_ff;
    logic [3:0] sync3_ff;
    logic [WORD_W-1:0] shift_ff;
    logic [WORD_W-1:0] ctl_ff;
    logic [WORD_W-1:0] ref_ff;
    logic [WORD_W-1:0] fb_ff;
    logic [WORD_W-1:0] test_ff;
    logic powered_ff;
    logic cp_en_ff;
    logic series_ff;
    logic shunt_ff;
    logic [FB_B_W-1:0] main_ff;
    logic [FB_A_W-1:0] swallow_ff;
    logic fb_pulse_ff;
    logic fb_div_ff;
    logic ref_div_ff;
    logic obs_ff;
    logic pre_pulse;

    // link lines: {chip_enable, load_strobe, sdata, sclk}
    // third stage only feeds the edge detectors, never the first
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            sync1_ff <= 4'h0;
            sync2_ff <= 4'h0;
            sync3_ff <= 4'h0;
        end else begin
            sync1_ff <= {link.chip_enable, link.load_strobe,
                         link.sdata, link.sclk};
            sync2_ff <= sync1_ff;
            sync3_ff <= sync2_ff;
        end
    end

    // all four lines see the same delay, so data keeps its setup
    // and hold against the clock edge after synchronising
    wire sclk_rise = sync2_ff[0] & ~sync3_ff[0];
    wire sdata_s = sync2_ff[1];
    wire strobe_rise = sync2_ff[2] & ~sync3_ff[2];
    wire chip_en_s = sync2_ff[3];

    // shift register, newest bit at the low end
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            shift_ff <= {WORD_W{1'b0}};
        end else if (sclk_rise) begin
            shift_ff <= {shift_ff[WORD_W-2:0], sdata_s};
        end
    end

    // latch select decode from the two low bits
    wire [SEL_W-1:0] sel = shift_ff[SEL_W-1:0];
    wire wr_ctl = strobe_rise & (sel == SEL_CTL);
    wire wr_ref = strobe_rise & (sel == SEL_REF);
    wire wr_fb = strobe_rise & (sel == SEL_FB);
    wire wr_test = strobe_rise & (sel == SEL_TEST);

    // latches hold until a strobe picks them; shifting alone
    // never disturbs a latch
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            ctl_ff <= {WORD_W{1'b0}};
            ref_ff <= {WORD_W{1'b0}};
            fb_ff <= {WORD_W{1'b0}};
            test_ff <= {WORD_W{1'b0}};
        end else begin
            if (wr_ctl) begin
                ctl_ff <= shift_ff;
            end
            if (wr_ref) begin
                ref_ff <= shift_ff;
            end
            if (wr_fb) begin
                fb_ff <= shift_ff;
            end
            if (wr_test) begin
                test_ff <= shift_ff;
            end
        end
    end

    // power: pin gates everything, the soft bit may keep it down
    wire soft_down = ctl_ff[CTL_PD1];
    wire pwr_on = chip_en_s & ~soft_down;
    wire pump_on = pwr_on & ~ctl_ff[CTL_CP3S];

    // reset leaves the part in its powered-down posture
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            powered_ff <= 1'b0;
            cp_en_ff <= 1'b0;
            series_ff <= 1'b0;
            shunt_ff <= 1'b1;
        end else begin
            powered_ff <= pwr_on;
            cp_en_ff <= pump_on;
            series_ff <= pwr_on;
            shunt_ff <= ~pwr_on;
        end
    end

    // feedback counter values; main below its floor is clamped
    // because a shorter main count cannot cover the swallow phase
    wire [1:0] pre_mode = ctl_ff[CTL_PRE_LSB +: 2];
    wire [FB_B_W-1:0] b_raw = fb_ff[FB_B_LSB +: FB_B_W];
    wire [FB_B_W-1:0] b_val = (b_raw < B_MIN) ? B_MIN : b_raw;
    wire [FB_A_W-1:0] a_val = fb_ff[FB_A_LSB +: FB_A_W];
    wire run = pwr_on & ~ctl_ff[CTL_CR];
    wire swallow_on = (swallow_ff != {FB_A_W{1'b0}});
    wire main_last = (main_ff == {{(FB_B_W-1){1'b0}}, 1'b1});

    ssfd_prescaler u_pre (
        .pclk(pclk),
        .presetn(presetn),
        .tick(rf_tick),
        .run(run),
        .mode(pre_mode),
        .hi_mod(swallow_on),
        .out_pulse(pre_pulse)
    );

    // swallow then main: b prescaler cycles, first a at p+1
    // so one feedback cycle spans b*p + a rf cycles
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            main_ff <= {FB_B_W{1'b0}};
            swallow_ff <= {FB_A_W{1'b0}};
            fb_pulse_ff <= 1'b0;
        end else if (!run) begin
            main_ff <= b_val;
            swallow_ff <= a_val;
            fb_pulse_ff <= 1'b0;
        end else begin
            fb_pulse_ff <= pre_pulse & main_last;
            if (pre_pulse && main_last) begin
                main_ff <= b_val;
                swallow_ff <= a_val;
            end else if (pre_pulse) begin
                main_ff <= main_ff - 13'h0001;
                if (swallow_on) begin
                    swallow_ff <= swallow_ff - 5'h01;
                end
            end
        end
    end

    // halved copies of feedback and reference rates for viewing
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            fb_div_ff <= 1'b0;
            ref_div_ff <= 1'b0;
        end else begin
            if (fb_pulse_ff) begin
                fb_div_ff <= ~fb_div_ff;
            end
            if (ref_tick) begin
                ref_div_ff <= ~ref_div_ff;
            end
        end
    end

    // observation select; unused codes drive low
    wire [2:0] mux_sel = ctl_ff[CTL_MUX_LSB +: 3];
    wire obs_nxt = (mux_sel == MUX_LOCK) ? lock_detect :
                   (mux_sel == MUX_FB) ? fb_div_ff :
                   (mux_sel == MUX_REF) ? ref_div_ff : 1'b0;

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            obs_ff <= 1'b0;
        end else begin
            obs_ff <= obs_nxt;
        end
    end

    // outputs straight from their registers
    assign link.observation_output_pin = obs_ff;
    assign feedback_pulse = fb_pulse_ff;
    assign powered_up = powered_ff;
    assign charge_pump_output_en = cp_en_ff;
    assign ref_series_switch_one_closed = series_ff;
    assign ref_series_switch_two_closed = series_ff;
    assign ref_shunt_switch_closed = shunt_ff;
    assign control_latch = ctl_ff;
    assign reference_latch = ref_ff;
    assign feedback_latch = fb_ff;
    assign test_latch = test_ff;
endmodule : ssfd_device

// ==== rtl/ssfd_host.sv ====
`timescale 1ns/1ps
module ssfd_host #(
    parameter int SCLK_HALF = ssfd_pkg::SCLK_HALF_CYC
) (
    // system
    input wire logic pclk,
    input wire logic presetn,
    // apb slave
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    // interrupt
    output logic irq,
    // serial programming link
    ssfd_link_if.host link
);
    import ssfd_pkg::*;

    ssfd_hstate_t state_ff;
    logic [WORD_W-1:0] word_ff;
    logic [4:0] bit_ff;
    logic [7:0] div_ff;
    logic sclk_ff, sdata_ff, le_ff, ce_ff;
    logic done_ff, drop_ff;
    logic [1:0] mask_ff;
    logic seen_ref_ff, seen_ctl_ff;
    logic [1:0] pcode_ff;
    logic obs1_ff, obs2_ff;
    logic [31:0] prdata_ff;
    logic pready_ff, pslverr_ff, irq_ff;

    // apb decode: zero-wait slave, pready rises in the access cycle
    wire setup = psel & ~penable & ~pready_ff;
    wire acc = psel & penable & pready_ff;
    wire hit_word = (paddr == REG_WORD);
    wire hit_ctrl = (paddr == REG_CTRL);
    wire hit_stat = (paddr == REG_STAT);
    wire hit_mask = (paddr == REG_MASK);
    wire mapped = hit_word | hit_ctrl | hit_stat | hit_mask;
    wire wr = acc & pwrite & mapped;
    wire busy = (state_ff != HS_IDLE);
    wire [31:0] stat_v = {28'h0000000, obs2_ff, busy, drop_ff, done_ff};
    wire [31:0] rd_v = hit_ctrl ? {31'h00000000, ce_ff} :
                       hit_stat ? stat_v :
                       hit_mask ? {30'h00000000, mask_ff} : 32'h00000000;

    // word checks before anything reaches the link
    wire [1:0] wsel = pwdata[1:0];
    wire [18:0] pval = PRE_BASE << ((pcode_ff == 2'h3) ? 2'h2 : pcode_ff);
    wire [18:0] nmin = 19'(pval * pval) - pval;
    wire [18:0] nb = {6'h00, pwdata[FB_B_LSB +: FB_B_W]};
    wire [18:0] na = {14'h0000, pwdata[FB_A_LSB +: FB_A_W]};
    wire [18:0] nval = 19'(nb * pval) + na;
    wire not_test = (wsel != SEL_TEST);
    wire order_ok = (wsel == SEL_REF) | ((wsel == SEL_CTL) & seen_ref_ff) |
                    ((wsel == SEL_FB) & seen_ctl_ff);
    wire ratio_ok = (wsel != SEL_FB) | (nval >= nmin);
    wire wr_word = wr & hit_word;
    wire start = wr_word & ~busy & not_test & order_ok & ratio_ok;
    wire refuse = wr_word & ~start;
    wire tick = (div_ff == 8'(SCLK_HALF - 1));

    // apb answer registers
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            prdata_ff <= 32'h00000000;
            pready_ff <= 1'b0;
            pslverr_ff <= 1'b0;
        end else begin
            pready_ff <= setup;
            pslverr_ff <= setup & ~mapped;
            prdata_ff <= setup ? rd_v : 32'h00000000;
        end
    end

    // control, mask, sticky status (set beats clear), interrupt
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            ce_ff <= 1'b0;
            mask_ff <= 2'h0;
            done_ff <= 1'b0;
            drop_ff <= 1'b0;
            irq_ff <= 1'b0;
            obs1_ff <= 1'b0;
            obs2_ff <= 1'b0;
        end else begin
            obs1_ff <= link.observation_output_pin;
            obs2_ff <= obs1_ff;
            if (wr && hit_ctrl) begin
                ce_ff <= pwdata[0];
            end
            if (wr && hit_mask) begin
                mask_ff <= pwdata[1:0];
            end
            done_ff <= (done_ff & ~(wr & hit_stat & pwdata[ST_DONE])) |
                       (state_ff == HS_LOAD && tick && le_ff);
            drop_ff <= (drop_ff & ~(wr & hit_stat & pwdata[ST_DROP])) |
                       refuse;
            irq_ff <= |({drop_ff, done_ff} & mask_ff);
        end
    end

    // sequence tracking for the power-up load order
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            seen_ref_ff <= 1'b0;
            seen_ctl_ff <= 1'b0;
            pcode_ff <= 2'h0;
        end else if (start) begin
            if (wsel == SEL_REF) begin
                seen_ref_ff <= 1'b1;
            end
            if (wsel == SEL_CTL) begin
                seen_ctl_ff <= 1'b1;
                pcode_ff <= pwdata[CTL_PRE_LSB +: 2];
            end
        end
    end

    // serial sequencer: data changes on the fall, device takes it
    // on the rise; strobe follows the last fall by a half period
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            state_ff <= HS_IDLE;
            word_ff <= {WORD_W{1'b0}};
            bit_ff <= 5'h00;
            div_ff <= 8'h00;
            sclk_ff <= 1'b0;
            sdata_ff <= 1'b0;
            le_ff <= 1'b0;
        end else begin
            div_ff <= (!busy || tick) ? 8'h00 : div_ff + 8'h01;
            unique case (state_ff)
                HS_IDLE: begin
                    if (start) begin
                        word_ff <= pwdata[WORD_W-1:0];
                        sdata_ff <= pwdata[WORD_W-1];
                        bit_ff <= 5'(WORD_W - 1);
                        state_ff <= HS_SHIFT;
                    end
                end
                HS_SHIFT: begin
                    if (tick && !sclk_ff) begin
                        sclk_ff <= 1'b1;
                    end else if (tick) begin
                        sclk_ff <= 1'b0;
                        if (bit_ff == 5'h00) begin
                            state_ff <= HS_LOAD;
                        end else begin
                            bit_ff <= bit_ff - 5'h01;
                            sdata_ff <= word_ff[bit_ff - 5'h01];
                        end
                    end
                end
                HS_LOAD: begin
                    if (tick && !le_ff) begin
                        le_ff <= 1'b1;
                    end else if (tick) begin
                        le_ff <= 1'b0;
                        state_ff <= HS_IDLE;
                    end
                end
            endcase
        end
    end

    assign prdata = prdata_ff;
    assign pready = pready_ff;
    assign pslverr = pslverr_ff;
    assign irq = irq_ff;
    assign link.sclk = sclk_ff;
    assign link.sdata = sdata_ff;
    assign link.load_strobe = le_ff;
    assign link.chip_enable = ce_ff;
endmodule : ssfd_host

// ==== testbench/ssfd_link_sva.sv ====
`timescale 1ns/1ps
module ssfd_link_sva #(
    parameter int SCLK_HALF = 1
) (
    // system
    input wire logic pclk,
    input wire logic presetn,
    // serial link
    input wire logic sclk,
    input wire logic sdata,
    input wire logic load_strobe,
    input wire logic chip_enable,
    input wire logic observation_output_pin
);
    logic [7:0] hi_ff, lo_ff, st_ff, nxt_hi, nxt_lo, nxt_st;
    logic [4:0] bits_ff, nxt_bits;
    logic sclk_q_ff;
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);
    // run lengths; the low count saturates so a long idle cannot wrap
    assign nxt_hi = sclk ? hi_ff + 8'h01 : 8'h00;
    assign nxt_lo = sclk ? 8'h00 : lo_ff + {7'h00, lo_ff != 8'hff};
    assign nxt_st = load_strobe ? st_ff + 8'h01 : 8'h00;
    assign nxt_bits = load_strobe ? 5'h00 :
                      bits_ff + {4'h0, sclk & ~sclk_q_ff};
    // bookkeeping for one word
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            hi_ff <= 8'h00;
            lo_ff <= 8'h00;
            st_ff <= 8'h00;
            bits_ff <= 5'h00;
            sclk_q_ff <= 1'b0;
        end else begin
            hi_ff <= nxt_hi;
            lo_ff <= nxt_lo;
            st_ff <= nxt_st;
            bits_ff <= nxt_bits;
            sclk_q_ff <= sclk;
        end
    end
    a_clk_high_width:
    assert property ($fell(sclk) |-> hi_ff == 8'(SCLK_HALF))
        else $error("serial clock high time wrong");
    a_clk_low_width:
    assert property ($rose(sclk) |-> lo_ff >= 8'(SCLK_HALF))
        else $error("serial clock low time too short");
    a_data_held_rise:
    assert property ($rose(sclk) |-> $stable(sdata))
        else $error("data moved at clock rise");
    a_data_moves_low:
    assert property ($changed(sdata) |-> !sclk)
        else $error("data moved while clock high");
    a_word_bit_count:
    assert property ($rose(load_strobe) |-> bits_ff == 5'(ssfd_pkg::WORD_W))
        else $error("strobe after wrong bit count");
    a_strobe_width:
    assert property ($fell(load_strobe) |-> st_ff == 8'(SCLK_HALF))
        else $error("strobe width wrong");
    a_strobe_clk_low:
    assert property (load_strobe |-> !sclk)
        else $error("clock high during strobe");
    a_strobe_setup:
    assert property ($rose(load_strobe) |-> lo_ff >= 8'(SCLK_HALF))
        else $error("strobe too soon after clock");
    // main scenarios
    cover property ($rose(load_strobe));
    cover property ($fell(chip_enable));
    cover property ($rose(observation_output_pin));
endmodule : ssfd_link_sva

// ==== testbench/ssfd_link_tb.sv ====
`timescale 1ns/1ps
module ssfd_link_tb;
    import ssfd_pkg::*;
    localparam int HALF = 2;
    logic pclk = 1'b0;
    logic presetn = 1'b0;
    logic psel = 1'b0, penable = 1'b0, pwrite = 1'b0, mask_v = 1'b0;
    logic [11:0] paddr = 12'h000;
    logic [31:0] pwdata = 32'h0, prdata, r;
    logic pready, pslverr, irq, err, fb_pulse, up, pump_en, sw1, sw2, shunt;
    logic rf_tick = 1'b0, ref_tick = 1'b0, lock_detect = 1'b0;
    logic [23:0] ctl_l, ref_l, fb_l, tst_l;
    int n_fail = 0, checks = 0, tcnt = 0, period = 0, npulse = 0;
    ssfd_link_if link_i ();
    ssfd_host #(.SCLK_HALF(HALF)) ssfd_host_i (.pclk, .presetn, .psel,
        .penable, .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr,
        .irq, .link(link_i));
    ssfd_device ssfd_device_i (.pclk, .presetn, .link(link_i), .rf_tick,
        .ref_tick, .lock_detect, .feedback_pulse(fb_pulse), .powered_up(up),
        .charge_pump_output_en(pump_en), .ref_series_switch_one_closed(sw1),
        .ref_series_switch_two_closed(sw2), .ref_shunt_switch_closed(shunt),
        .control_latch(ctl_l), .reference_latch(ref_l),
        .feedback_latch(fb_l), .test_latch(tst_l));
    ssfd_link_sva #(.SCLK_HALF(HALF)) ssfd_link_sva_i (.pclk, .presetn,
        .sclk(link_i.sclk), .sdata(link_i.sdata),
        .load_strobe(link_i.load_strobe), .chip_enable(link_i.chip_enable),
        .observation_output_pin(link_i.observation_output_pin));
    always #25 pclk = ~pclk;
    // rf and ref enables on alternate cycles; ticks counted pulse to pulse
    always @(posedge pclk) begin
        rf_tick <= ~rf_tick;
        ref_tick <= rf_tick;
        if (fb_pulse === 1'b1) begin
            period <= tcnt + rf_tick;
            tcnt <= 0;
            npulse <= npulse + 1;
        end else begin
            tcnt <= tcnt + rf_tick;
        end
    end
    task automatic complete_run;
        $display("checks %0d n_fail %0d", checks, n_fail);
        if (n_fail == 0 && checks > 0) begin
            $display("No errors found");
        end else begin
            $display("Errors were found");
        end
        $finish;
    endtask : complete_run
    task automatic fail(input string m);
        n_fail++;
        $display("mismatch at %0t: %s", $time, m);
    endtask : fail
    task automatic cmp(input logic [31:0] g, input logic [31:0] e,
                       input string m);
        checks++;
        if (g !== e) begin
            fail(m);
        end
    endtask : cmp
    // one apb transfer; the request stands until pready is seen high
    task automatic apb(input logic w, input logic [11:0] a,
                       input logic [31:0] d);
        int k;
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        for (k = 0; k < 50; k++) begin
            @(posedge pclk);
            if (pready === 1'b1) begin
                break;
            end
        end
        // answer taken at the edge that sees pready high
        r = prdata;
        err = pslverr;
        if (k == 50) begin
            fail("apb timeout");
            complete_run();
        end
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge pclk);
    endtask : apb
    // send a word, wait until idle, check and clear the status bits
    task automatic send(input logic [23:0] w, input logic [1:0] exp,
                        input string m);
        int k;
        apb(1'b1, REG_WORD, {8'h00, w});
        for (k = 0; k < 100; k++) begin
            apb(1'b0, REG_STAT, 32'h0);
            if (r[ST_BUSY] === 1'b0) begin
                break;
            end
        end
        if (k == 100) begin
            fail("link timeout");
            complete_run();
        end
        repeat (4) @(posedge pclk);
        apb(1'b0, REG_STAT, 32'h0);
        cmp(r[1:0], exp, m);
        cmp(irq, mask_v, "irq raised");
        apb(1'b1, REG_STAT, 32'h3);
        @(negedge pclk);
        cmp(irq, 1'b0, "irq cleared");
        @(posedge pclk);
    endtask : send
    function automatic logic [23:0] ctlw(input logic [1:0] p,
                                         input logic [2:0] m);
        return {p, 14'h0000, m, 3'h0, SEL_CTL};
    endfunction : ctlw
    function automatic logic [23:0] fbw(input logic [12:0] b,
                                        input logic [4:0] a);
        return {3'h0, b, 1'b0, a, SEL_FB};
    endfunction : fbw
    // main sequence
    initial begin
        int p, k, n0;
        repeat (6) @(posedge pclk);
        presetn <= 1'b1;
        @(negedge pclk);
        cmp(ctl_l | ref_l | fb_l | tst_l, 32'h0, "latch reset");
        cmp({up, pump_en, sw1, sw2, shunt}, 5'h01, "reset power");
        @(posedge pclk);
        apb(1'b0, 12'h010, 32'h0);
        cmp(r, 32'h0, "unmapped read");
        cmp(err, 1'b1, "unmapped error");
        apb(1'b1, REG_MASK, 32'h3);
        mask_v = 1'b1;
        send(fbw(13'h0008, 5'h03), 2'h2, "fb first");
        send(24'h000003, 2'h2, "test word");
        cmp(fb_l | tst_l, 32'h0, "latches kept");
        send(24'h123451, 2'h1, "ref word");
        cmp(ref_l, 24'h123451, "ref latch");
        send(ctlw(PRE_8, MUX_LOCK), 2'h1, "ctl word");
        cmp(ctl_l, ctlw(PRE_8, MUX_LOCK), "ctl latch");
        send(fbw(13'h0006, 5'h01), 2'h2, "ratio low");
        cmp(fb_l, 32'h0, "fb kept");
        send(fbw(13'h0008, 5'h03), 2'h1, "fb word");
        cmp(fb_l, fbw(13'h0008, 5'h03), "fb latch");
        apb(1'b1, REG_CTRL, 32'h1);
        lock_detect <= 1'b1;
        repeat (6) @(posedge pclk);
        cmp({up, pump_en, sw1, sw2, shunt}, 5'h1e, "power up");
        apb(1'b0, REG_STAT, 32'h0);
        cmp({r[ST_OBS], link_i.observation_output_pin}, 2'h3, "obs");
        // each modulus, largest swallow count
        for (int i = 0; i < 3; i++) begin
            p = 8 << i;
            send(ctlw(2'(i), MUX_REF), 2'h1, "ctl mode");
            send(fbw(13'(p), 5'(p - 1)), 2'h1, "fb mode");
            n0 = npulse;
            for (k = 0; k < 9000 && npulse < n0 + 3; k++) begin
                @(posedge pclk);
            end
            if (npulse < n0 + 3) begin
                fail("divider timeout");
                complete_run();
            end
            cmp(period, p * p + p - 1, "feedback ratio");
        end
        // reference shows through the observation pin
        n0 = 0;
        for (k = 0; k < 20; k++) begin
            @(negedge pclk);
            n0 += int'(link_i.observation_output_pin);
        end
        @(posedge pclk);
        cmp(n0 > 0 && n0 < 20, 1'b1, "obs ref toggles");
        // pump floats by its own bit; observe halved feedback rate
        send(ctlw(PRE_8, MUX_FB) | (24'h1 << CTL_CP3S), 2'h1, "pump off");
        cmp({up, pump_en, sw1, sw2, shunt}, 5'h16, "pump off");
        r[0] = link_i.observation_output_pin;
        for (k = 0; k < 1500; k++) begin
            @(posedge pclk);
            if (link_i.observation_output_pin !== r[0]) begin
                break;
            end
        end
        cmp(k < 1500, 1'b1, "obs fb toggles");
        if (k == 1500) begin
            complete_run();
        end
        apb(1'b1, REG_MASK, 32'h0);
        mask_v = 1'b0;
        send(ctlw(PRE_8, 3'h0), 2'h1, "masked done");
        cmp(link_i.observation_output_pin, 1'b0, "obs off");
        apb(1'b1, REG_CTRL, 32'h0);
        repeat (6) @(posedge pclk);
        cmp({up, pump_en, sw1, sw2, shunt}, 5'h01, "power down");
        n0 = npulse;
        repeat (200) @(posedge pclk);
        cmp(npulse, n0, "divider held");
        // soft power-down bit keeps the part down with the pin high
        send(ctlw(PRE_8, 3'h0) | (24'h1 << CTL_PD1), 2'h1, "soft pd");
        apb(1'b1, REG_CTRL, 32'h1);
        repeat (6) @(posedge pclk);
        cmp({up, pump_en, sw1, sw2, shunt}, 5'h01, "soft down");
        complete_run();
    end
endmodule : ssfd_link_tb
